// [design/hta_attach.sv]
// Attaches the third link controller to one channel of the E1 frame.
//
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/100ps

// What this block does
// R1 - Enable bit seven attaches the third link controller; clear disconnects it.
// R2 - Low five bits hold the unsigned channel the controller occupies.
// R3 - Channels count zero for the first through thirty-one for the last.
// R4 - Transmit: controller bits replace serial input bits in the chosen channel.
// R5 - Receive: controller bits come from line data ahead of elastic buffer.
// R6 - Channel zero can never be occupied by this controller.
// R7 - Host writes zero into reserved bits six and five.
// R8 - Serial input is continuous 2.048 Mb/s, or gapped 8.192 Mb/s when fast.
// R9 - Outside the attached channel, serial input passes through unchanged.
module hta_attach (
    // Clock and reset.
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    // AXI4-Lite register slave.
    input wire logic [11:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    input wire logic [11:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    // Transmit datapath: serial input in, merged stream out.
    input wire logic i_tx_bit_valid,
    input wire logic i_tx_frame_start,
    input wire logic i_tx_slot_active,
    input wire logic i_serial_tx_data_in,
    output logic o_tx_bit_valid,
    output logic o_tx_data_out,
    // Receive datapath: line data ahead of the elastic buffer.
    input wire logic i_rx_bit_valid,
    input wire logic i_rx_frame_start,
    input wire logic i_rx_line_data,
    // Third link controller, transmit bytes in.
    input wire logic i_link_tx_valid,
    input wire logic [7:0] i_link_tx_data,
    output logic o_link_tx_ready,
    // Third link controller, receive bytes out.
    output logic o_link_rx_valid,
    output logic [7:0] o_link_rx_data
);
    // ******************************************************************
    // Helpers
    // ******************************************************************

    // True when a bit count falls in the given attached channel.
    function automatic logic in_slot(input logic [7:0] cnt,
                                     input logic on,
                                     input logic [4:0] slot);
        in_slot = on && (cnt[7:3] == slot);
    endfunction

    // Byte lane 0 merge honouring the write strobe.
    function automatic logic [7:0] lane0(input logic [7:0] old,
                                         input logic [31:0] wd,
                                         input logic [3:0] st);
        lane0 = st[0] ? wd[7:0] : old;
    endfunction

    logic sel_enable;
    logic [hta_pkg::SLOT_W-1:0] slot_number;
    logic fast_rate_select;
    logic underrun;
    logic attach_active;
    logic [hta_pkg::LEVEL_W-1:0] fifo_level;

    // Channel zero is refused even when enabled.
    assign attach_active = sel_enable
        && (slot_number != hta_pkg::SLOT_FIRST); // R1 R6

    // ******************************************************************
    // AXI4-Lite register slave
    // ******************************************************************
    logic aw_got;
    logic w_got;
    logic [11:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic wr_fire;
    logic wr_hit;
    logic underrun_set;
    logic [7:0] sel_wr;

    assign wr_fire = aw_got && w_got && !o_bvalid;
    assign wr_hit = (aw_addr == hta_pkg::ADDR_SLOT_SEL)
        || (aw_addr == hta_pkg::ADDR_CONTROL)
        || (aw_addr == hta_pkg::ADDR_STATUS);
    assign sel_wr = lane0({sel_enable, 2'b00, slot_number}, w_data, w_strb);

    // Address and data are taken in either order; ready drops until
    // the response is accepted, so one write is in flight at a time.
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            aw_got <= 1'b0;
            w_got <= 1'b0;
            aw_addr <= '0;
            w_data <= '0;
            w_strb <= '0;
            o_awready <= 1'b0;
            o_wready <= 1'b0;
            o_bvalid <= 1'b0;
            o_bresp <= hta_pkg::RESP_OKAY;
        end else begin
            if (i_awvalid && o_awready) begin
                aw_got <= 1'b1;
                aw_addr <= {i_awaddr[11:2], 2'b00};
                o_awready <= 1'b0;
            end else if (!aw_got && !o_bvalid) begin
                o_awready <= 1'b1;
            end
            if (i_wvalid && o_wready) begin
                w_got <= 1'b1;
                w_data <= i_wdata;
                w_strb <= i_wstrb;
                o_wready <= 1'b0;
            end else if (!w_got && !o_bvalid) begin
                o_wready <= 1'b1;
            end
            if (wr_fire) begin
                aw_got <= 1'b0;
                w_got <= 1'b0;
                o_bvalid <= 1'b1;
                o_bresp <= wr_hit ? hta_pkg::RESP_OKAY
                                  : hta_pkg::RESP_SLVERR;
            end else if (o_bvalid && i_bready) begin
                o_bvalid <= 1'b0;
            end
        end
    end

    // Slot select and control. Reserved bits six and five are not
    // stored, so a careless write there cannot disturb the routing.
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            sel_enable <= hta_pkg::SLOT_SEL_RESET[hta_pkg::SEL_ENABLE_BIT];
            slot_number <= hta_pkg::SLOT_SEL_RESET[4:0];
            fast_rate_select <= hta_pkg::CONTROL_FAST_RESET;
        end else if (wr_fire) begin
            if (aw_addr == hta_pkg::ADDR_SLOT_SEL) begin
                sel_enable <= sel_wr[hta_pkg::SEL_ENABLE_BIT]; // R1 R7
                slot_number <= sel_wr[hta_pkg::SEL_SLOT_MSB:0]; // R2
            end
            if (aw_addr == hta_pkg::ADDR_CONTROL && w_strb[0]) begin
                fast_rate_select <= w_data[hta_pkg::CTL_FAST_BIT]; // R8
            end
        end
    end

    logic [11:0] rd_addr;
    logic [31:0] next_rdata;
    logic [1:0] next_rresp;

    assign rd_addr = {i_araddr[11:2], 2'b00};

    // Read decode; unmapped words answer zero with a slave error.
    always_comb begin
        next_rdata = '0;
        next_rresp = hta_pkg::RESP_OKAY;
        case (rd_addr)
            hta_pkg::ADDR_SLOT_SEL: begin
                next_rdata[7:0] = {sel_enable, 2'b00, slot_number};
            end
            hta_pkg::ADDR_CONTROL: begin
                next_rdata[hta_pkg::CTL_FAST_BIT] = fast_rate_select;
            end
            hta_pkg::ADDR_STATUS: begin
                next_rdata[hta_pkg::STS_UNDERRUN_BIT] = underrun;
                next_rdata[hta_pkg::STS_ACTIVE_BIT] = attach_active;
                next_rdata[hta_pkg::STS_LEVEL_LSB +: hta_pkg::LEVEL_W] =
                    fifo_level;
            end
            default: begin
                next_rresp = hta_pkg::RESP_SLVERR;
            end
        endcase
    end

    // One read at a time: arready is withheld while data is pending.
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_arready <= 1'b0;
            o_rvalid <= 1'b0;
            o_rdata <= '0;
            o_rresp <= hta_pkg::RESP_OKAY;
        end else begin
            if (i_arvalid && o_arready) begin
                o_arready <= 1'b0;
                o_rvalid <= 1'b1;
                o_rdata <= next_rdata;
                o_rresp <= next_rresp;
            end else if (o_rvalid && i_rready) begin
                o_rvalid <= 1'b0;
            end else if (!o_rvalid) begin
                o_arready <= 1'b1;
            end
        end
    end

    // ******************************************************************
    // Transmit FIFO and merge
    // ******************************************************************
    hta_stream_if #(.W(hta_pkg::FIFO_W)) fill_if ();
    hta_stream_if #(.W(hta_pkg::FIFO_W)) drain_if ();

    assign fill_if.valid = i_link_tx_valid;
    assign fill_if.data = i_link_tx_data;
    assign o_link_tx_ready = fill_if.ready;

    hta_fifo #(
        .WIDTH(hta_pkg::FIFO_W),
        .DEPTH(hta_pkg::FIFO_D),
        .LVL_W(hta_pkg::LEVEL_W)
    ) u_tx_fifo (
        .i_core_clk(i_core_clk),
        .i_reset_n(i_reset_n),
        .fill(fill_if.dst),
        .drain(drain_if.src),
        .o_level(fifo_level)
    );

    logic tx_take;
    logic [7:0] tx_cur;
    logic [7:0] tx_cnt;
    logic tx_hit;
    logic [7:0] tx_shift;
    logic [7:0] tx_byte;

    // In gapped fast mode only the active quarter of each slot carries
    // a bit, so strobes outside it are ignored.
    assign tx_take = i_tx_bit_valid
        && (!fast_rate_select || i_tx_slot_active); // R8
    assign tx_cur = i_tx_frame_start ? 8'h00 : tx_cnt; // R3
    assign tx_hit = in_slot(tx_cur, attach_active, slot_number); // R2 R4
    assign tx_byte = drain_if.valid ? drain_if.data : hta_pkg::IDLE_BYTE;
    assign drain_if.ready = tx_take && tx_hit && (tx_cur[2:0] == 3'h0);
    assign underrun_set = drain_if.ready && !drain_if.valid;

    // Bit position within the frame; wraps after channel thirty-one.
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            tx_cnt <= '0;
        end else if (tx_take) begin
            tx_cnt <= tx_cur + 8'h01; // R3
        end
    end

    // Merged output, most significant bit of each byte first.
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_tx_bit_valid <= 1'b0;
            o_tx_data_out <= 1'b0;
            tx_shift <= '0;
        end else begin
            o_tx_bit_valid <= tx_take;
            if (tx_take && tx_hit && tx_cur[2:0] == 3'h0) begin
                o_tx_data_out <= tx_byte[7]; // R4
                tx_shift <= {tx_byte[6:0], 1'b0};
            end else if (tx_take && tx_hit) begin
                o_tx_data_out <= tx_shift[7]; // R4
                tx_shift <= {tx_shift[6:0], 1'b0};
            end else if (tx_take) begin
                o_tx_data_out <= i_serial_tx_data_in; // R9
            end
        end
    end

    // Underrun is sticky; a write of one clears it, but a new underrun
    // in the same cycle wins so no event is lost.
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            underrun <= 1'b0;
        end else if (underrun_set) begin
            underrun <= 1'b1;
        end else if (wr_fire && aw_addr == hta_pkg::ADDR_STATUS
                     && w_strb[0] && w_data[hta_pkg::STS_UNDERRUN_BIT]) begin
            underrun <= 1'b0;
        end
    end

    // ******************************************************************
    // Receive extraction
    // ******************************************************************
    logic [7:0] rx_cur;
    logic [7:0] rx_cnt;
    logic rx_hit;
    logic [7:0] rx_shift;

    assign rx_cur = i_rx_frame_start ? 8'h00 : rx_cnt; // R3
    assign rx_hit = in_slot(rx_cur, attach_active, slot_number); // R2 R5

    // Bits are tapped from the raw line, before any elastic store.
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rx_cnt <= '0;
            rx_shift <= '0;
            o_link_rx_valid <= 1'b0;
            o_link_rx_data <= '0;
        end else begin
            o_link_rx_valid <= 1'b0;
            if (i_rx_bit_valid) begin
                rx_cnt <= rx_cur + 8'h01;
                if (rx_hit) begin
                    rx_shift <= {rx_shift[6:0], i_rx_line_data}; // R5
                end
                if (rx_hit && rx_cur[2:0] == hta_pkg::BIT_LAST) begin
                    o_link_rx_valid <= 1'b1;
                    o_link_rx_data <= {rx_shift[6:0], i_rx_line_data};
                end
            end
        end
    end

    // ******************************************************************
    // Checks
    // ******************************************************************
    chk_enable_gates_attach: assert property ( // R1
        @(posedge i_core_clk) disable iff (!i_reset_n)
        !sel_enable |-> !attach_active && !drain_if.ready)
        else $error("Attachment active while disabled.");
    chk_slot_zero_refused: assert property ( // R6
        @(posedge i_core_clk) disable iff (!i_reset_n)
        slot_number == hta_pkg::SLOT_FIRST |-> !tx_hit && !rx_hit)
        else $error("Channel zero was occupied.");
    chk_tx_pass_through: assert property ( // R9
        @(posedge i_core_clk) disable iff (!i_reset_n)
        tx_take && !tx_hit |=> o_tx_bit_valid
            && o_tx_data_out == $past(i_serial_tx_data_in))
        else $error("Serial input altered outside attached channel.");
    chk_tx_substitute: assert property ( // R4
        @(posedge i_core_clk) disable iff (!i_reset_n)
        tx_take && tx_hit && tx_cur[2:0] == 3'h0 |=>
            o_tx_data_out == $past(tx_byte[7]))
        else $error("Controller bit not substituted.");
    chk_frame_wrap: assert property ( // R3
        @(posedge i_core_clk) disable iff (!i_reset_n)
        tx_take && tx_cur == 8'hff |=> tx_cnt == 8'h00)
        else $error("Frame counter did not wrap after slot 31.");
    chk_fast_gap: assert property ( // R8
        @(posedge i_core_clk) disable iff (!i_reset_n)
        fast_rate_select && !i_tx_slot_active |=> !o_tx_bit_valid)
        else $error("Gapped bit taken in fast mode.");
    chk_rx_byte_slot: assert property ( // R2 R5
        @(posedge i_core_clk) disable iff (!i_reset_n)
        o_link_rx_valid |-> $past(rx_hit) && $past(i_rx_bit_valid)
            && $past(rx_cur[2:0]) == hta_pkg::BIT_LAST)
        else $error("Receive byte outside selected channel.");
    chk_write_response: assert property (
        @(posedge i_core_clk) disable iff (!i_reset_n)
        $rose(o_bvalid) |-> $past(aw_got) && $past(w_got))
        else $error("Write answered before address and data.");
    chk_read_hold: assert property (
        @(posedge i_core_clk) disable iff (!i_reset_n)
        o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
        else $error("Read data dropped before accepted.");
endmodule

// [design/hta_fifo.sv]
// Flip-flop FIFO with valid and ready on both sides.
`timescale 1ns/100ps
module hta_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16,
    parameter int LVL_W = 5
) (
    // Clock and reset.
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    // Fill and drain sides.
    hta_stream_if.dst fill,
    hta_stream_if.src drain,
    // Occupancy.
    output logic [LVL_W-1:0] o_level
);
    localparam int PTR_W = $clog2(DEPTH);
    localparam logic [LVL_W-1:0] FULL_LVL = LVL_W'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [LVL_W-1:0] next_level;
    logic push;
    logic pop;

    assign push = fill.valid && fill.ready;
    assign pop = drain.valid && drain.ready;
    assign drain.valid = (o_level != '0);
    assign drain.data = mem[rd_ptr];
    assign next_level = o_level + LVL_W'(push) - LVL_W'(pop);

    // Storage is written only, so it needs no reset.
    always_ff @(posedge i_core_clk) begin
        if (push) begin
            mem[wr_ptr] <= fill.data;
        end
    end

    // Pointers, level and a registered ready so that ready never
    // depends combinationally on the filling side.
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            o_level <= '0;
            fill.ready <= 1'b0;
        end else begin
            wr_ptr <= push ? wr_ptr + 1'b1 : wr_ptr;
            rd_ptr <= pop ? rd_ptr + 1'b1 : rd_ptr;
            o_level <= next_level;
            fill.ready <= (next_level < FULL_LVL);
        end
    end

    chk_fifo_no_overfill: assert property (
        @(posedge i_core_clk) disable iff (!i_reset_n)
        o_level == FULL_LVL |-> !fill.ready)
        else $error("FIFO ready while full.");
endmodule

// [design/hta_pkg.sv]
// Constants shared by the timeslot attach block and its FIFO.
package hta_pkg;
    // Register indices; the byte address is four times the index.
    localparam logic [9:0] REG_SLOT_SEL_IDX = 10'h01b;
    localparam logic [9:0] REG_CONTROL_IDX = 10'h020;
    localparam logic [9:0] REG_STATUS_IDX = 10'h021;
    localparam logic [11:0] ADDR_SLOT_SEL = {REG_SLOT_SEL_IDX, 2'b00};
    localparam logic [11:0] ADDR_CONTROL = {REG_CONTROL_IDX, 2'b00};
    localparam logic [11:0] ADDR_STATUS = {REG_STATUS_IDX, 2'b00};
    // Field positions of the slot-select register.
    localparam int SEL_ENABLE_BIT = 7;
    localparam int SEL_SLOT_MSB = 4;
    // Field positions of the control and status registers.
    localparam int CTL_FAST_BIT = 0;
    localparam int STS_UNDERRUN_BIT = 0;
    localparam int STS_ACTIVE_BIT = 1;
    localparam int STS_LEVEL_LSB = 8;
    // Reset values.
    localparam logic [7:0] SLOT_SEL_RESET = 8'h00;
    localparam logic CONTROL_FAST_RESET = 1'b0;
    // Frame geometry: 32 channels of 8 bits.
    localparam int SLOT_W = 5;
    localparam int BIT_CNT_W = 8;
    localparam logic [SLOT_W-1:0] SLOT_FIRST = 5'h00;
    localparam logic [SLOT_W-1:0] SLOT_LAST = 5'h1f;
    localparam logic [2:0] BIT_LAST = 3'h7;
    // Byte sent when the controller has nothing queued.
    localparam logic [7:0] IDLE_BYTE = 8'hff;
    // Transmit FIFO shape.
    localparam int FIFO_W = 8;
    localparam int FIFO_D = 16;
    localparam int LEVEL_W = 5;
    // AXI responses.
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// [design/hta_stream_if.sv]
// Valid/ready byte stream carrier between the top and its FIFO.
`timescale 1ns/100ps
interface hta_stream_if #(parameter int W = 8);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport dst (input valid, input data, output ready);
endinterface

// [sim/hta_partner.sv]
// Frame-timed serial datapath model that faces the attach block.
`timescale 1ns/100ps
module hta_partner (
    // Clock and reset.
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    // Run request and rate mode.
    input wire logic i_run,
    input wire logic i_fast,
    // Frame datapath toward the block.
    output logic o_busy,
    output logic o_bit_valid,
    output logic o_tx_frame_start,
    output logic o_slot_active,
    output logic o_tx_data,
    output logic o_rx_bit_valid,
    output logic o_rx_frame_start,
    output logic o_rx_line_data
);
    // ***************************************************
    // Frame counter and strobes
    // ***************************************************
    int seed = 56;
    logic [7:0] cnt;
    logic [7:0] nc;
    logic take;
    // A frame once begun runs to its end, so setup only changes between
    // frames and no bit is in flight while the bench stands still.
    assign take = o_bit_valid && (!i_fast || o_slot_active);
    assign nc = take ? cnt + 8'h01 : cnt;
    assign o_busy = o_bit_valid || (cnt != 8'h00);
    // Strobes come at random spacing; data lines draw a new random bit every cycle,
    // strobe or not, so the value under each strobe is independent of the last.
    always @(posedge i_core_clk or negedge i_reset_n) begin
        logic v;
        logic a;
        if (!i_reset_n) begin
            cnt <= 8'h00;
            o_bit_valid <= 1'b0;
            o_tx_frame_start <= 1'b0;
            o_slot_active <= 1'b0;
            o_rx_bit_valid <= 1'b0;
            o_rx_frame_start <= 1'b0;
            o_tx_data <= 1'b0;
            o_rx_line_data <= 1'b0;
        end else begin
            v = (i_run || nc != 8'h00) && $random(seed) % 2;
            a = $random(seed) % 2;
            cnt <= nc;
            o_bit_valid <= v;
            o_slot_active <= a;
            o_tx_frame_start <= (nc == 8'h00);
            o_rx_bit_valid <= v && (!i_fast || a);
            o_rx_frame_start <= (nc == 8'h00);
            o_tx_data <= $random(seed) % 2;
            o_rx_line_data <= $random(seed) % 2;
        end
    end
endmodule

// [sim/tb_hdlc_timeslot_attach.sv]
// Self-checking bench for the third link controller slot attach block.
`timescale 1ns/100ps
module tb_hdlc_timeslot_attach;
    // ***************************************************
    // Signals, instances and checks
    // ***************************************************
    logic i_core_clk = 1'b0;
    logic i_reset_n = 1'b0;
    logic [11:0] i_awaddr = '0, i_araddr = '0;
    logic [31:0] i_wdata = '0, rdv;
    logic [3:0] i_wstrb = '0;
    logic i_awvalid = 0, i_wvalid = 0, i_bready = 0, i_arvalid = 0;
    logic i_rready = 0, i_link_tx_valid = 0, run = 0, fast = 0;
    logic [7:0] i_link_tx_data = '0, o_link_rx_data, cur = 8'hff;
    logic [7:0] rsh = '0, e_rx = '0, tc = '0, rc = '0, q[$];
    logic [31:0] o_rdata;
    logic [1:0] o_bresp, o_rresp, resp;
    logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, busy;
    logic o_tx_bit_valid, o_tx_data_out, o_link_tx_ready, o_link_rx_valid;
    logic i_tx_bit_valid, i_tx_frame_start, i_tx_slot_active;
    logic i_serial_tx_data_in, i_rx_bit_valid, i_rx_frame_start;
    logic i_rx_line_data, m_en = 0, m_und = 0, e_tx = 0;
    logic pend_t = 0, pend_r = 0;
    logic [4:0] m_sel = '0;
    int seed = 56, err_total = 0, n_tests = 0, fcnt = 0;
    // The clock toggles every 4 ns, half of its 8 ns period.
    always #4 i_core_clk = ~i_core_clk;
    hta_attach hta_attach_i (.i_core_clk, .i_reset_n, .i_awaddr,
        .i_awvalid, .o_awready, .i_wdata, .i_wstrb, .i_wvalid, .o_wready,
        .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid, .o_arready,
        .o_rdata, .o_rresp, .o_rvalid, .i_rready, .i_tx_bit_valid,
        .i_tx_frame_start, .i_tx_slot_active, .i_serial_tx_data_in,
        .o_tx_bit_valid, .o_tx_data_out, .i_rx_bit_valid, .i_rx_frame_start,
        .i_rx_line_data, .i_link_tx_valid, .i_link_tx_data, .o_link_tx_ready,
        .o_link_rx_valid, .o_link_rx_data);
    hta_partner hta_partner_i (.i_core_clk, .i_reset_n, .i_run(run),
        .i_fast(fast), .o_busy(busy), .o_bit_valid(i_tx_bit_valid),
        .o_tx_frame_start(i_tx_frame_start), .o_slot_active(i_tx_slot_active),
        .o_tx_data(i_serial_tx_data_in), .o_rx_bit_valid(i_rx_bit_valid),
        .o_rx_frame_start(i_rx_frame_start), .o_rx_line_data(i_rx_line_data));
    task automatic cmp_bit(input string nm, input logic e, input logic g);
        n_tests++;
        if (g !== e) begin
            err_total++;
            $display("BAD %s exp %b got %b", nm, e, g);
        end
    endtask
    task automatic cmp_word(input string nm, input logic [31:0] e,
                            input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            err_total++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Address and data go out together; each drops once it is taken.
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge i_core_clk);
        i_awaddr <= a;
        i_wdata <= d;
        i_wstrb <= 4'hf;
        i_awvalid <= 1'b1;
        i_wvalid <= 1'b1;
        i_bready <= 1'b1;
        do begin
            @(posedge i_core_clk);
            if (o_awready) i_awvalid <= 1'b0;
            if (o_wready) i_wvalid <= 1'b0;
        end while (!o_bvalid);
        cmp_bit("bvalid", 1'b1, o_bvalid);
        resp = o_bresp;
        i_bready <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a);
        @(posedge i_core_clk);
        i_araddr <= a;
        i_arvalid <= 1'b1;
        i_rready <= 1'b1;
        do begin
            @(posedge i_core_clk);
            if (o_arready) i_arvalid <= 1'b0;
        end while (!o_rvalid);
        cmp_bit("rvalid", 1'b1, o_rvalid);
        rdv = o_rdata;
        resp = o_rresp;
        i_rready <= 1'b0;
    endtask
    task automatic push(input logic [7:0] b);
        @(posedge i_core_clk);
        i_link_tx_valid <= 1'b1;
        i_link_tx_data <= b;
        do @(posedge i_core_clk); while (!o_link_tx_ready);
        i_link_tx_valid <= 1'b0;
        q.push_back(b);
    endtask
    function automatic logic [31:0] exp_sts();
        return {19'h0, 5'(q.size()), 6'h0, m_en && m_sel != 0, m_und};
    endfunction
    // Setup happens only while the frame model stands still.
    task automatic cfg(input logic en, input logic [4:0] s, input logic f);
        wr(hta_pkg::ADDR_SLOT_SEL, {24'h0, en, 2'b00, s});
        cmp_word("sel_resp", 32'h0, {30'h0, resp});
        wr(hta_pkg::ADDR_CONTROL, {31'h0, f});
        m_en = en;
        m_sel = s;
        fast <= f;
        rd(hta_pkg::ADDR_SLOT_SEL);
        cmp_word("sel_read", {24'h0, en, 2'b00, s}, rdv);
        rd(hta_pkg::ADDR_STATUS);
        cmp_word("status", exp_sts(), rdv);
    endtask
    task automatic frames(input int n);
        int k;
        k = fcnt + n;
        run <= 1'b1;
        while (fcnt < k) @(posedge i_core_clk);
        run <= 1'b0;
        @(posedge i_core_clk);
        while (busy) @(posedge i_core_clk);
        repeat (3) @(posedge i_core_clk);
    endtask
    // Each taken bit predicts the merged bit and the extracted byte.
    always @(posedge i_core_clk) begin
        if (i_reset_n) begin
            cmp_bit("tx_valid", pend_t, o_tx_bit_valid);
            if (pend_t) cmp_bit("tx_data", e_tx, o_tx_data_out);
            cmp_bit("rx_valid", pend_r, o_link_rx_valid);
            if (pend_r) cmp_word("rx_byte", e_rx, o_link_rx_data);
        end
        pend_t = 0;
        pend_r = 0;
        if (i_reset_n && i_tx_bit_valid && (!fast || i_tx_slot_active)) begin
            if (i_tx_frame_start) begin
                tc = 0;
                fcnt++;
            end
            if (m_en && m_sel != 0 && tc[7:3] == m_sel) begin
                if (tc[2:0] == 0) begin
                    m_und = m_und || q.size() == 0;
                    cur = q.size() ? q.pop_front() : 8'hff;
                end
                e_tx = cur[3'h7 - tc[2:0]];
            end else e_tx = i_serial_tx_data_in;
            pend_t = 1;
            tc++;
        end
        if (i_reset_n && i_rx_bit_valid) begin
            if (i_rx_frame_start) rc = 0;
            if (m_en && m_sel != 0 && rc[7:3] == m_sel) begin
                rsh = {rsh[6:0], i_rx_line_data};
                pend_r = (rc[2:0] == 3'h7);
                e_rx = rsh;
            end
            rc++;
        end
    end
    initial begin
        #700000;
        err_total++;
        end_sim;
    end
    initial begin
        repeat (8) @(posedge i_core_clk);
        i_reset_n <= 1'b1;
        repeat (2) @(posedge i_core_clk);
        rd(hta_pkg::ADDR_SLOT_SEL);
        cmp_word("sel_reset", 32'h0, rdv);
        rd(hta_pkg::ADDR_CONTROL);
        cmp_word("ctl_reset", 32'h0, rdv);
        wr(12'hffc, 32'h0000_00ff);
        cmp_word("wr_unmapped", {30'h0, hta_pkg::RESP_SLVERR}, {30'h0, resp});
        rd(12'hffc);
        cmp_word("rd_unmapped", {30'h0, hta_pkg::RESP_SLVERR}, {30'h0, resp});
        $display("test reset_map done");
        cfg(1'b0, 5'h03, 1'b0);
        frames(2);
        cfg(1'b1, 5'h00, 1'b0);
        frames(1);
        $display("test pass_through done");
        repeat (16) push($random(seed));
        repeat (3) @(posedge i_core_clk);
        cmp_bit("full_ready", 1'b0, o_link_tx_ready);
        cfg(1'b1, 5'h1f, 1'b1);
        frames(18);
        rd(hta_pkg::ADDR_STATUS);
        cmp_word("underrun", exp_sts(), rdv);
        wr(hta_pkg::ADDR_STATUS, 32'h0000_0001);
        m_und = 0;
        rd(hta_pkg::ADDR_STATUS);
        cmp_word("underrun_clr", exp_sts(), rdv);
        $display("test fill_drain done");
        repeat (6) begin
            cfg(1'b1, 5'($random(seed)) | 5'h01, 1'($random(seed)));
            repeat (3) push($random(seed));
            frames(2);
        end
        $display("test random_slots done");
        end_sim;
    end
endmodule
